/* logic/chan_status_pkg.sv */
// Constants and types for the channel status and error counter bank
package chan_status_pkg;

  // Register addresses on the management interface
  localparam logic [4:0]  REG_STATUS    = 5'h0F;
  localparam logic [4:0]  REG_HS_ERR    = 5'h10;
  localparam logic [4:0]  REG_LANE_ERR  = 5'h11;

  // Status bit positions
  localparam int BIT_PAT_OK     = 15;
  localparam int BIT_TRAIN_FAIL = 14;
  localparam int BIT_SIG_LOST   = 13;
  localparam int BIT_AZ_DONE    = 12;
  localparam int BIT_GAIN_LOCK  = 11;
  localparam int BIT_WORD_SYNC  = 10;
  localparam int BIT_BAD_CODE   = 8;
  localparam int BIT_MARKER     = 4;
  localparam int BIT_FRAME_LOCK = 3;
  localparam int BIT_RX_READY   = 2;
  localparam int BIT_LS_PLL     = 1;
  localparam int BIT_HS_PLL     = 0;

  // Reset values and unmapped read data
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] ERR_RESET     = 16'hFFFD;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;

  // Management frame fields
  localparam logic [5:0]  PRE_LEN       = 6'h20;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [4:0]  ADDR_LAST     = 5'h09;
  localparam logic [4:0]  DATA_LAST     = 5'h0F;

  typedef enum logic [2:0] {
    S_PRE  = 3'h0,
    S_ST   = 3'h1,
    S_OP   = 3'h2,
    S_ADDR = 3'h3,
    S_TA   = 3'h4,
    S_DATA = 3'h5
  } mgmt_state_t;

endpackage : chan_status_pkg

/* logic/sat_clear_counter.sv */
// Saturating clear-on-read error counter
`timescale 1ns/1ps
`default_nettype none
module sat_clear_counter
  import chan_status_pkg::*;
#(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] RESET_VAL = ERR_RESET
) (
  input  wire logic             i_clk,   // System clock
  input  wire logic             i_rst,   // Synchronous reset
  input  wire logic             i_inc,   // One error this cycle
  input  wire logic             i_clear, // Read clears count
  output logic      [WIDTH-1:0] o_count  // Current count
);

  // Refuse widths the reset value cannot fill
  if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
    $error("sat_clear_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_state_t;

  cnt_state_t st_ff;
  cnt_state_t nxt_st;

  // -----------------------------------------------------------------
  // Next count
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (i_clear) begin
      nxt_st.count = {{(WIDTH-1){1'b0}}, i_inc}; // error in clear cycle kept
    end else if (i_inc && !(&st_ff.count)) begin
      nxt_st.count = st_ff.count + 1'b1;        // hold at all ones
    end
  end

  // Register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff.count <= RESET_VAL[WIDTH-1:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count = st_ff.count;

endmodule : sat_clear_counter
`default_nettype wire

/* logic/chan_status_regs.sv */
// Channel status flags and error counters behind the management interface
`timescale 1ns/1ps
`default_nettype none
module chan_status_regs
  import chan_status_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00, // Management address of this port
  parameter int         LANES    = 4      // Low-side lanes
) (
  input  wire logic             I_SYS_CLK,                    // 250 MHz clock
  input  wire logic             I_RST,                        // Sync reset, high
  input  wire logic             I_MDC,                        // Management clock pin
  input  wire logic             I_MDIO_IN,                    // Management data in
  output logic                  O_MDIO_OUT,                   // Management data out
  output logic                  O_MDIO_OE_N,                  // Drive enable, low
  input  wire logic             I_HIGH_SIDE_PATTERN_CHECK_OK, // Pattern aligned
  input  wire logic             I_LINK_TRAIN_FAILED,          // Training fail event
  input  wire logic             I_HIGH_SIDE_SIGNAL_LOST,      // Signal loss
  input  wire logic             I_HIGH_SIDE_AUTOZERO_DONE,    // Calibration done
  input  wire logic             I_HIGH_SIDE_GAIN_LOOP_LOCKED, // Gain loop lock
  input  wire logic             I_HIGH_SIDE_WORD_SYNC,        // Word sync
  input  wire logic             I_HIGH_SIDE_BAD_CODEWORD,     // Bad codeword pulse
  input  wire logic             I_RX_BIT_INTERLEAVE_MODE,     // Interleave mode
  input  wire logic             I_BIT_MARKER_SEARCH_DONE,     // Marker found
  input  wire logic             I_TRAIN_FRAME_LOCKED,         // Frame delineated
  input  wire logic             I_RX_TRAINED_READY,           // Receiver ready
  input  wire logic             I_LOW_SIDE_PLL_LOCKED,        // Low PLL lock
  input  wire logic             I_HIGH_SIDE_PLL_LOCKED,       // High PLL lock
  input  wire logic             I_HS_TP_VERIFY_MODE,          // High pattern mode
  input  wire logic             I_HS_TP_ERR,                  // Pattern error pulse
  input  wire logic             I_PRBS_CHECK_PIN,             // PRBS check pin
  input  wire logic             I_HS_PRBS_ERR,                // PRBS error pulse
  input  wire logic             I_LS_TP_VERIFY_MODE,          // Lane pattern mode
  input  wire logic [2:0]       I_LANE_SELECT_FIELD,          // Lane select
  input  wire logic [LANES-1:0] I_LANE_BAD_CODEWORD,          // Per-lane bad code
  input  wire logic [LANES-1:0] I_LANE_TP_ERR                 // Per-lane pattern err
);

  // Refuse lane counts the three-bit select cannot reach
  if (LANES < 1 || LANES > 8) begin : g_bad_lanes
    $error("chan_status_regs: LANES out of range");
  end

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------

  // Pick one lane's error, none for a lane that is absent
  function automatic logic pick_lane(input logic [LANES-1:0] errs,
                                     input logic [2:0]       sel);
    logic res;
    res = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      if (sel == 3'(i)) begin
        res = errs[i];
      end
    end
    return res;
  endfunction : pick_lane

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mdc_sync;   // Pin synchroniser
    logic [1:0]  mdio_sync;  // Pin synchroniser
    logic [1:0]  prbs_sync;  // Pin synchroniser
    logic        mdc_prev;   // For rising edge
    mgmt_state_t state;
    logic [5:0]  ones;       // Preamble ones seen
    logic [4:0]  cnt;        // Bit count in field
    logic [1:0]  op;
    logic [9:0]  addr;       // Port and register address
    logic        rd_ok;      // Read for this port
    logic [15:0] shift;      // Read data out
    logic        mdio_out;
    logic        mdio_oe_n;
    logic [3:0]  lh;         // Latched-high holds
    logic [4:0]  ll;         // Latched-low drop seen
    logic        hs_inc;
    logic        lane_inc;
  } regs_state_t;

  regs_state_t st_ff;
  regs_state_t nxt_st;

  logic        mdc_rise;
  logic        bit_in;
  logic [9:0]  full_addr;
  logic        take_read;
  logic        rd_status;
  logic        rd_hs;
  logic        rd_lane;
  logic [3:0]  lh_event;
  logic [4:0]  ll_live;
  logic [15:0] status_word;
  logic [15:0] hs_count;
  logic [15:0] lane_count;
  logic [15:0] read_word;

  // -----------------------------------------------------------------
  // Frame decode
  // -----------------------------------------------------------------

  // Synchronised pins only
  assign mdc_rise  = st_ff.mdc_sync[1] & ~st_ff.mdc_prev;
  assign bit_in    = st_ff.mdio_sync[1];
  assign full_addr = {st_ff.addr[8:0], bit_in};

  // Read taken on last address bit; clears act in that cycle
  assign take_read = mdc_rise && (st_ff.state == S_ADDR) &&
                     (st_ff.cnt == ADDR_LAST) && (st_ff.op == OP_READ) &&
                     (full_addr[9:5] == PHY_ADDR);
  assign rd_status = take_read && (full_addr[4:0] == REG_STATUS);
  assign rd_hs     = take_read && (full_addr[4:0] == REG_HS_ERR);
  assign rd_lane   = take_read && (full_addr[4:0] == REG_LANE_ERR);

  // -----------------------------------------------------------------
  // Status word
  // -----------------------------------------------------------------

  // Latch-high events: train fail, signal lost, bad code, marker
  assign lh_event[3] = I_LINK_TRAIN_FAILED;
  assign lh_event[2] = I_HIGH_SIDE_SIGNAL_LOST;
  assign lh_event[1] = I_HIGH_SIDE_BAD_CODEWORD;
  assign lh_event[0] = I_BIT_MARKER_SEARCH_DONE & I_RX_BIT_INTERLEAVE_MODE;

  // Latch-low live levels: autozero, gain, sync, low PLL, high PLL
  assign ll_live = {I_HIGH_SIDE_AUTOZERO_DONE,
                    I_HIGH_SIDE_GAIN_LOOP_LOCKED,
                    I_HIGH_SIDE_WORD_SYNC,
                    I_LOW_SIDE_PLL_LOCKED,
                    I_HIGH_SIDE_PLL_LOCKED};

  // Assemble the word; held value or live, reserved bits zero
  always_comb begin
    status_word                 = STATUS_RESET;
    status_word[BIT_PAT_OK]     = I_HIGH_SIDE_PATTERN_CHECK_OK;
    status_word[BIT_TRAIN_FAIL] = st_ff.lh[3] | lh_event[3];
    status_word[BIT_SIG_LOST]   = st_ff.lh[2] | lh_event[2];
    status_word[BIT_BAD_CODE]   = st_ff.lh[1] | lh_event[1];
    status_word[BIT_MARKER]     = st_ff.lh[0] | lh_event[0];
    status_word[BIT_AZ_DONE]    = ll_live[4] & ~st_ff.ll[4];
    status_word[BIT_GAIN_LOCK]  = ll_live[3] & ~st_ff.ll[3];
    status_word[BIT_WORD_SYNC]  = ll_live[2] & ~st_ff.ll[2];
    status_word[BIT_LS_PLL]     = ll_live[1] & ~st_ff.ll[1];
    status_word[BIT_HS_PLL]     = ll_live[0] & ~st_ff.ll[0];
    status_word[BIT_FRAME_LOCK] = I_TRAIN_FRAME_LOCKED;
    status_word[BIT_RX_READY]   = I_RX_TRAINED_READY;
  end

  // Read data mux, unmapped reads as zero
  always_comb begin
    unique case (full_addr[4:0])
      REG_STATUS:   read_word = status_word;
      REG_HS_ERR:   read_word = hs_count;
      REG_LANE_ERR: read_word = lane_count;
      default:      read_word = UNMAPPED_DATA;
    endcase
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.mdc_sync  = {st_ff.mdc_sync[0], I_MDC};
    nxt_st.mdio_sync = {st_ff.mdio_sync[0], I_MDIO_IN};
    nxt_st.prbs_sync = {st_ff.prbs_sync[0], I_PRBS_CHECK_PIN};
    nxt_st.mdc_prev  = st_ff.mdc_sync[1];

    // Holds: a read clears, an event in the same cycle wins
    nxt_st.lh = (rd_status ? 4'h0 : st_ff.lh) | lh_event;
    nxt_st.ll = (rd_status ? 5'h00 : st_ff.ll) | ~ll_live;

    // High-side counter source: PRBS pin, then pattern mode, else decode
    if (st_ff.prbs_sync[1]) begin
      nxt_st.hs_inc = I_HS_PRBS_ERR;
    end else if (I_HS_TP_VERIFY_MODE) begin
      nxt_st.hs_inc = I_HS_TP_ERR;
    end else begin
      nxt_st.hs_inc = I_HIGH_SIDE_BAD_CODEWORD;
    end

    // Lane counter source for the selected lane
    if (I_LS_TP_VERIFY_MODE) begin
      nxt_st.lane_inc = pick_lane(I_LANE_TP_ERR, I_LANE_SELECT_FIELD);
    end else begin
      nxt_st.lane_inc = pick_lane(I_LANE_BAD_CODEWORD, I_LANE_SELECT_FIELD);
    end

    // Frame machine, one step per management clock rise
    if (mdc_rise) begin
      unique case (st_ff.state)
        S_PRE: begin
          if (bit_in) begin
            if (st_ff.ones != PRE_LEN) begin
              nxt_st.ones = st_ff.ones + 1'b1;
            end
          end else if (st_ff.ones == PRE_LEN) begin
            nxt_st.state = S_ST;
          end else begin
            nxt_st.ones = 6'h00;
          end
        end
        S_ST: begin
          nxt_st.ones  = 6'h00;
          nxt_st.cnt   = 5'h00;
          nxt_st.state = bit_in ? S_OP : S_PRE;
        end
        S_OP: begin
          nxt_st.op  = {st_ff.op[0], bit_in};
          nxt_st.cnt = st_ff.cnt + 1'b1;
          if (st_ff.cnt != 5'h00) begin
            nxt_st.cnt   = 5'h00;
            nxt_st.state = S_ADDR;
          end
        end
        S_ADDR: begin
          nxt_st.addr = full_addr;
          nxt_st.cnt  = st_ff.cnt + 1'b1;
          if (st_ff.cnt == ADDR_LAST) begin
            nxt_st.cnt   = 5'h00;
            nxt_st.rd_ok = take_read;
            nxt_st.shift = read_word;
            nxt_st.state = S_TA;
          end
        end
        S_TA: begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
          if (st_ff.cnt == 5'h00) begin
            // Second turnaround bit driven low on reads
            nxt_st.mdio_oe_n = ~st_ff.rd_ok;
            nxt_st.mdio_out  = 1'b0;
          end else begin
            nxt_st.cnt       = 5'h00;
            nxt_st.mdio_out  = st_ff.rd_ok & st_ff.shift[15]; // Data out stays low when not answering; line released
            nxt_st.shift     = {st_ff.shift[14:0], 1'b0};
            nxt_st.state     = S_DATA;
          end
        end
        S_DATA: begin
          nxt_st.cnt      = st_ff.cnt + 1'b1;
          nxt_st.mdio_out = st_ff.rd_ok & st_ff.shift[15];
          nxt_st.shift    = {st_ff.shift[14:0], 1'b0};
          if (st_ff.cnt == DATA_LAST) begin
            // Release after the last data bit
            nxt_st.mdio_oe_n = 1'b1;
            nxt_st.mdio_out  = 1'b0;
            nxt_st.rd_ok     = 1'b0;
            nxt_st.cnt       = 5'h00;
            nxt_st.state     = S_PRE;
          end
        end
        default: begin
          nxt_st.state = S_PRE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      st_ff           <= '0;
      st_ff.state     <= S_PRE;
      st_ff.mdio_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -----------------------------------------------------------------
  // Error counters
  // -----------------------------------------------------------------
  sat_clear_counter #(
    .WIDTH     (16),
    .RESET_VAL (ERR_RESET)
  ) u_hs_count (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_inc   (st_ff.hs_inc),
    .i_clear (rd_hs),
    .o_count (hs_count)
  );

  sat_clear_counter #(
    .WIDTH     (16),
    .RESET_VAL (ERR_RESET)
  ) u_lane_count (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_inc   (st_ff.lane_inc),
    .i_clear (rd_lane),
    .o_count (lane_count)
  );

  assign O_MDIO_OUT  = st_ff.mdio_out;
  assign O_MDIO_OE_N = st_ff.mdio_oe_n;

endmodule : chan_status_regs
`default_nettype wire

/* tb/chan_status_regs_props.sv */
// Protocol checker on the management pins of the status bank
`timescale 1ns/1ps
`default_nettype none
module chan_status_regs_props (
  input wire logic I_SYS_CLK,  // System clock
  input wire logic I_RST,      // Sync reset, high
  input wire logic I_MDC,      // Management clock
  input wire logic O_MDIO_OUT, // Data out
  input wire logic O_MDIO_OE_N // Drive enable, low
);
  // ----------------------------------------
  // Rises of the management clock while driving
  // ----------------------------------------
  logic       mdc_ff;
  logic [4:0] rise_ff;
  always_ff @(posedge I_SYS_CLK) begin
    mdc_ff  <= I_MDC;
    rise_ff <= (I_RST || O_MDIO_OE_N) ? 5'h00 : rise_ff + 5'(I_MDC && !mdc_ff);
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reset_quiet;
    $fell(I_RST) |-> O_MDIO_OE_N && !O_MDIO_OUT;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins not quiet after reset");

  property p_idle_low;
    O_MDIO_OE_N |-> !O_MDIO_OUT;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("data high while released");

  property p_turn_zero;
    $fell(O_MDIO_OE_N) |-> !O_MDIO_OUT;
  endproperty
  a_turn_zero: assert property (p_turn_zero) else $error("turnaround bit not zero");

  property p_word_len;
    $rose(O_MDIO_OE_N) |-> rise_ff == 5'h11;
  endproperty
  a_word_len: assert property (p_word_len) else $error("drive window not 17 clocks");

  property p_oe_after_mdc;
    $changed(O_MDIO_OE_N) |-> $past(I_MDC, 2);
  endproperty
  a_oe_after_mdc: assert property (p_oe_after_mdc) else $error("enable moved off clock rise");

  property p_bit_after_mdc;
    !O_MDIO_OE_N && $changed(O_MDIO_OUT) |-> $past(I_MDC, 2);
  endproperty
  a_bit_after_mdc: assert property (p_bit_after_mdc) else $error("data moved off clock rise");

  property p_stands;
    $fell(I_MDC) |=> ($stable(O_MDIO_OUT) && $stable(O_MDIO_OE_N)) [*8];
  endproperty
  a_stands: assert property (p_stands) else $error("pins moved in clock low");

  property p_no_spont;
    $stable(I_MDC) [*8] |-> $stable(O_MDIO_OE_N);
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("enable moved without clock");

  c_drive: cover property ($fell(O_MDIO_OE_N));
  c_word: cover property ($rose(O_MDIO_OE_N) && rise_ff == 5'h11);
  c_reset: cover property ($fell(I_RST));
endmodule : chan_status_regs_props

bind chan_status_regs chan_status_regs_props i_chan_status_regs_props (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_MDC(I_MDC), .O_MDIO_OUT(O_MDIO_OUT), .O_MDIO_OE_N(O_MDIO_OE_N));
`default_nettype wire

/* tb/mgmt_host_model.sv */
// Management host model driving the serial management pins
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input  wire logic i_clk,  // System clock
  input  wire logic i_line, // Resolved data line
  output logic      o_mdc,  // Management clock
  output logic      o_do,   // Data driven
  output logic      o_oe    // Host drives line
);
  // Idle: clock low, line released
  initial begin
    o_mdc = 1'h0;
    o_do  = 1'h1;
    o_oe  = 1'h0;
  end

  // Half a management period, ten system clocks
  task automatic half();
    repeat (10) @(posedge i_clk);
    #1;
  endtask : half

  // One frame: 46 bits out, then 18 rises listening (two turnaround, sixteen data)
  task automatic read_reg(input logic [1:0] op, input logic [4:0] port, input logic [4:0] ra,
                          output logic ta, output logic [15:0] d);
    logic [45:0] f;
    f    = {32'hFFFF_FFFF, 2'h1, op, port, ra};
    o_oe = 1'h1;
    for (int i = 45; i >= -18; i--) begin
      if (i < 0) o_oe = 1'h0;
      else o_do = f[i];
      half();
      o_mdc = 1'h1;
      if (i == -2) ta = i_line;
      if (i < -2) d = {d[14:0], i_line};
      half();
      o_mdc = 1'h0;
    end
  endtask : read_reg
endmodule : mgmt_host_model
`default_nettype wire

/* tb/channel_status_error_counters_test.sv */
// Self-checking bench for the channel status and error counter bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module channel_status_error_counters_test;
  import chan_status_pkg::*;
  localparam int         LN   = 4;
  localparam logic [4:0] PORT = 5'h03;
  typedef struct packed { logic [12:0] lv; logic [15:0] ex; } row_t;

  logic I_SYS_CLK, I_RST, I_MDC, I_MDIO_IN, O_MDIO_OUT, O_MDIO_OE_N, h_do, h_oe, ta;
  logic I_HIGH_SIDE_PATTERN_CHECK_OK, I_LINK_TRAIN_FAILED, I_HIGH_SIDE_SIGNAL_LOST, I_HIGH_SIDE_AUTOZERO_DONE,
        I_HIGH_SIDE_GAIN_LOOP_LOCKED, I_HIGH_SIDE_WORD_SYNC, I_HIGH_SIDE_BAD_CODEWORD, I_RX_BIT_INTERLEAVE_MODE,
        I_BIT_MARKER_SEARCH_DONE, I_TRAIN_FRAME_LOCKED, I_RX_TRAINED_READY, I_LOW_SIDE_PLL_LOCKED,
        I_HIGH_SIDE_PLL_LOCKED, I_HS_TP_VERIFY_MODE, I_HS_TP_ERR, I_PRBS_CHECK_PIN, I_HS_PRBS_ERR,
        I_LS_TP_VERIFY_MODE;
  logic [2:0]    I_LANE_SELECT_FIELD;
  logic [LN-1:0] I_LANE_BAD_CODEWORD, I_LANE_TP_ERR;
  logic [12:0]   lv;
  logic [15:0]   rd;
  int            n_fail, compares;

  // Status rows: levels applied, then the status word expected
  row_t rows [8] = '{'{13'h0000, 16'h0000},
                     '{13'h138F, 16'h800C},
                     '{13'h138F, 16'h9C0F},
                     '{13'h1FFF, 16'hFD1F},
                     '{13'h138F, 16'hFD1F},
                     '{13'h138F, 16'h9C0F},
                     '{13'h139F, 16'h9C0F},
                     '{13'h0383, 16'h1C03}};

  assign {I_HIGH_SIDE_PATTERN_CHECK_OK, I_LINK_TRAIN_FAILED, I_HIGH_SIDE_SIGNAL_LOST, I_HIGH_SIDE_AUTOZERO_DONE,
          I_HIGH_SIDE_GAIN_LOOP_LOCKED, I_HIGH_SIDE_WORD_SYNC, I_HIGH_SIDE_BAD_CODEWORD, I_RX_BIT_INTERLEAVE_MODE,
          I_BIT_MARKER_SEARCH_DONE, I_TRAIN_FRAME_LOCKED, I_RX_TRAINED_READY, I_LOW_SIDE_PLL_LOCKED,
          I_HIGH_SIDE_PLL_LOCKED} = lv;
  // Data line with pull-up: device, else host, else high
  assign I_MDIO_IN = !O_MDIO_OE_N ? O_MDIO_OUT : (h_oe ? h_do : 1'h1);

  chan_status_regs #(.PHY_ADDR(PORT), .LANES(LN)) i_chan_status_regs (.I_SYS_CLK, .I_RST, .I_MDC, .I_MDIO_IN,
    .O_MDIO_OUT, .O_MDIO_OE_N, .I_HIGH_SIDE_PATTERN_CHECK_OK, .I_LINK_TRAIN_FAILED, .I_HIGH_SIDE_SIGNAL_LOST,
    .I_HIGH_SIDE_AUTOZERO_DONE, .I_HIGH_SIDE_GAIN_LOOP_LOCKED, .I_HIGH_SIDE_WORD_SYNC, .I_HIGH_SIDE_BAD_CODEWORD,
    .I_RX_BIT_INTERLEAVE_MODE, .I_BIT_MARKER_SEARCH_DONE, .I_TRAIN_FRAME_LOCKED, .I_RX_TRAINED_READY,
    .I_LOW_SIDE_PLL_LOCKED, .I_HIGH_SIDE_PLL_LOCKED, .I_HS_TP_VERIFY_MODE, .I_HS_TP_ERR, .I_PRBS_CHECK_PIN,
    .I_HS_PRBS_ERR, .I_LS_TP_VERIFY_MODE, .I_LANE_SELECT_FIELD, .I_LANE_BAD_CODEWORD, .I_LANE_TP_ERR);

  mgmt_host_model i_mgmt_host_model (.i_clk(I_SYS_CLK), .i_line(I_MDIO_IN), .o_mdc(I_MDC), .o_do(h_do),
    .o_oe(h_oe));

  // ----------------------------------------
  // Clock, watchdog and tasks
  // ----------------------------------------
  initial begin
    I_SYS_CLK = 1'h0;
    forever #2 I_SYS_CLK = ~I_SYS_CLK;
  end

  initial begin
    #400_000;
    n_fail++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic do_reset();
    I_RST = 1'h1;
    repeat (16) @(posedge I_SYS_CLK);
    #1;
    I_RST = 1'h0;
    repeat (4) @(posedge I_SYS_CLK);
    #1;
  endtask : do_reset

  // Read a register of this port and compare turnaround and data
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    i_mgmt_host_model.read_reg(OP_READ, PORT, ra, ta, rd);
    `CHK(ta, 1'h0)
    `CHK(rd, exp)
  endtask : rd_chk

  // n back-to-back error cycles: 0 bad code, 1 pattern, 2 PRBS
  task automatic burst(input int src, input int n);
    repeat (n) begin
      case (src)
        0: lv[6] = 1'h1;
        1: I_HS_TP_ERR = 1'h1;
        default: I_HS_PRBS_ERR = 1'h1;
      endcase
      @(posedge I_SYS_CLK);
      #1;
    end
    // Drop only the source raised, so a following burst never re-drives it in one step
    case (src)
      0: lv[6] = 1'h0;
      1: I_HS_TP_ERR = 1'h0;
      default: I_HS_PRBS_ERR = 1'h0;
    endcase
  endtask : burst

  // Lane k gets k+1 error cycles
  task automatic lanes(input logic tp);
    for (int c = 0; c < 4; c++) begin
      if (tp) I_LANE_TP_ERR = 4'hF << c;
      else I_LANE_BAD_CODEWORD = 4'hF << c;
      @(posedge I_SYS_CLK);
      #1;
    end
    if (tp) I_LANE_TP_ERR = '0;
    else I_LANE_BAD_CODEWORD = '0;
  endtask : lanes

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {lv, I_HS_TP_VERIFY_MODE, I_HS_TP_ERR, I_PRBS_CHECK_PIN, I_HS_PRBS_ERR, I_LS_TP_VERIFY_MODE} = '0;
    {I_LANE_SELECT_FIELD, I_LANE_BAD_CODEWORD, I_LANE_TP_ERR} = '0;
    n_fail   = 0;
    compares = 0;
    do_reset();
    rd_chk(REG_HS_ERR, ERR_RESET);
    rd_chk(REG_LANE_ERR, ERR_RESET);
    foreach (rows[i]) begin
      lv = rows[i].lv;
      rd_chk(REG_STATUS, rows[i].ex);
    end
    i_mgmt_host_model.read_reg(OP_READ, PORT, REG_HS_ERR, ta, rd);
    burst(0, 5);
    burst(1, 3);
    rd_chk(REG_HS_ERR, 16'h0005);
    rd_chk(REG_HS_ERR, 16'h0000);
    I_HS_TP_VERIFY_MODE = 1'h1;
    burst(0, 4);
    burst(1, 6);
    rd_chk(REG_HS_ERR, 16'h0006);
    I_PRBS_CHECK_PIN = 1'h1;
    repeat (4) @(posedge I_SYS_CLK);
    #1;
    burst(1, 2);
    burst(2, 7);
    rd_chk(REG_HS_ERR, 16'h0007);
    I_PRBS_CHECK_PIN    = 1'h0;
    I_HS_TP_VERIFY_MODE = 1'h0;
    for (int l = 0; l < 5; l++) begin
      I_LANE_SELECT_FIELD = 3'(l);
      lanes(1'h1);
      lanes(1'h0);
      rd_chk(REG_LANE_ERR, (l < LN) ? 16'(l + 1) : 16'h0000);
    end
    I_LS_TP_VERIFY_MODE = 1'h1;
    I_LANE_SELECT_FIELD = 3'h2;
    lanes(1'h0);
    lanes(1'h1);
    rd_chk(REG_LANE_ERR, 16'h0003);
    // Unmapped place, foreign port and write op
    rd_chk(5'h12, UNMAPPED_DATA);
    i_mgmt_host_model.read_reg(OP_READ, PORT + 5'h01, REG_STATUS, ta, rd);
    `CHK({ta, rd}, 17'h1_FFFF)
    i_mgmt_host_model.read_reg(2'h1, PORT, REG_STATUS, ta, rd);
    `CHK({ta, rd}, 17'h1_FFFF)
    // Second reset, then count past all ones
    do_reset();
    burst(0, 3);
    rd_chk(REG_HS_ERR, 16'hFFFF);
    rd_chk(REG_STATUS, 16'h1D03);
    report_and_stop();
  end
endmodule : channel_status_error_counters_test
`default_nettype wire
